/* File: design/prts_pkg.sv */
package prts_pkg;
    // clock rate and derived cycle counts
    localparam int CLK_PERIOD_PS = 8000;
    localparam int RST_STRETCH_NS = 800;
    localparam int LOCK_SETTLE_NS = 1600;
    localparam logic [7:0] RST_STRETCH_CNT =
        8'((RST_STRETCH_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS);
    localparam logic [7:0] LOCK_SETTLE_CNT =
        8'((LOCK_SETTLE_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS);

    // register byte offsets
    localparam logic [7:0] OFS_PLL_CTRL = 8'h00;
    localparam logic [7:0] OFS_PLL_STAT = 8'h04;
    localparam logic [7:0] OFS_RST_STAT = 8'h08;
    localparam logic [7:0] OFS_BR_RUN = 8'h0c;
    localparam logic [7:0] OFS_BR_AUTO = 8'h10;
    localparam logic [7:0] OFS_BR_WAKE = 8'h14;
    localparam logic [7:0] OFS_PMU_CTRL = 8'h18;
    localparam logic [7:0] OFS_BASE_STAT = 8'h1c;

    // pll control field positions and reset value
    localparam int PLL_PD_BIT = 0;
    localparam int PLL_BYP_BIT = 1;
    localparam int PLL_P23_BIT = 2;
    localparam int PLL_PSEL_LSB = 3;
    localparam int PLL_MSEL_LSB = 8;
    localparam logic [12:0] PLL_CTRL_RST = 13'h0101;
    localparam int PMU_DOWN_BIT = 0;

    // sizes of the reset tree and branch clock set
    localparam int NUM_LVL = 4;
    localparam int NUM_COLD = 5;
    localparam int NUM_WARM = 11;
    localparam int NUM_BR = 8;
    localparam int NUM_BASE = 9;

    // tied-off branch control bits; fixed bits of auto and wake read as zero
    localparam logic [7:0] RUN_FIX_MASK = 8'h0b;
    localparam logic [7:0] RUN_FIX_VAL = 8'h0b;
    localparam logic [7:0] AUTO_FIX_MASK = 8'h01;
    localparam logic [7:0] WAKE_FIX_MASK = 8'h01;
    localparam logic [7:0] BR_RUN_RST = 8'hff;

    // base clock of each branch, fixed in hardware
    localparam logic [NUM_BR-1:0][3:0] BR_BASE =
        {4'h6, 4'h5, 4'h4, 4'h3, 4'h2, 4'h1, 4'h1, 4'h0};

    typedef struct packed {
        logic [4:0] msel;
        logic [2:0] rsvd;
        logic [1:0] psel;
        logic phase_outputs_enable;
        logic bypass;
        logic pd;
    } prts_pll_ctrl_s;

    typedef enum logic [2:0] {
        LK_OFF = 3'b001,
        LK_SETTLE = 3'b010,
        LK_LOCKED = 3'b100
    } prts_lock_e;

    typedef enum logic [1:0] {
        PM_RUN = 2'b01,
        PM_DOWN = 2'b10
    } prts_pm_e;
endpackage

/* File: design/prts_top.sv */
// Behaviour
// - post divider by 2P or direct
// - feedback divider divides main output by M
// - lock detector flags lock of analog section
// - phase enable adds two 120 degree outputs
// - phase dividers resync to main at lock
// - psel picks divide 2/4/8/16, 50% duty
// - bypass routes oscillator straight to output
// - powerdown stops oscillator, detector, resets dividers
// - lock low while powered down
// - lock returns only after relock settles
// - each reset ORs all its sources
// - cascade: unit, subsystem, cold, warm levels
// - cold-domain resets follow cold level
// - warm-domain resets follow warm level
// - external reset input is active low
// - branch clocks switch by own bits
// - auto bits pick clocks stopped at powerdown
// - wake event restarts wake-enabled sleeping clocks
// - status shows bases with all branches off
// - branch-to-base mapping fixed in hardware
// - tied-off bits read constant, ignore writes
//
// Local design decisions: the address map and the APB register port.
`timescale 1ns/10ps
module prts_top (
    // apb clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // apb slave
    input wire logic [7:0] paddr,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // analog pll side, asynchronous
    input wire logic [2:0] controlled_oscillator,
    input wire logic analog_lock,
    output logic [2:0] pll_phase_out,
    output logic pll_main_output,
    output logic pll_fb_clk,
    output logic pll_analog_en,
    output logic pll_lock,
    // reset sources
    input wire logic por_n,
    input wire logic external_reset_n,
    input wire logic watchdog_rst,
    // reset outputs, active high
    output logic reset_unit_reset,
    output logic subsystem_ctrl_reset,
    output logic cold_level_reset,
    output logic warm_level_reset,
    output logic [prts_pkg::NUM_COLD-1:0] cold_domain_rst,
    output logic [prts_pkg::NUM_WARM-1:0] warm_domain_rst,
    // power management
    input wire logic wake_event,
    output logic [prts_pkg::NUM_BR-1:0] branch_clk_en
);

    // address match, shared by read and write decode
    function automatic logic reg_hit(input logic [7:0] a, input logic [7:0] ofs);
        reg_hit = (a == ofs);
    endfunction

    // a base may stop when no branch hanging off it is enabled
    function automatic logic base_idle(input logic [prts_pkg::NUM_BR-1:0] en,
                                       input logic [3:0] b);
        base_idle = 1'b1;
        for (int i = 0; i < prts_pkg::NUM_BR; i++) begin
            if (prts_pkg::BR_BASE[i] == b && en[i]) begin
                base_idle = 1'b0;
            end
        end
    endfunction

    prts_pkg::prts_pll_ctrl_s pll_q;
    prts_pkg::prts_lock_e lk_q, lk_d;
    prts_pkg::prts_pm_e pm_q, pm_d;
    logic [31:0] prdata_q, rd_mux;
    logic pready_q, pslverr_q, setup, acc_wr, rd_hit;
    logic [2:0][2:0] osc_sync_q;
    logic [2:0] osc_rise, div_out_q;
    logic [2:0][3:0] div_cnt_q;
    logic [3:0] half;
    logic [1:0] lock_sync_q, wake_sync_q, ext_sync_q, por_sync_q;
    logic [7:0] lk_cnt_q, fb_cnt_q, msel_eff;
    logic main_prev_q, fb_q, lock_q, lock_rise;
    logic [prts_pkg::NUM_LVL-1:0] lvl_src, lvl_q;
    logic [prts_pkg::NUM_LVL-1:0][7:0] lvl_cnt_q;
    logic [prts_pkg::NUM_COLD-1:0] cold_dom_q;
    logic [prts_pkg::NUM_WARM-1:0] warm_dom_q;
    logic [prts_pkg::NUM_BR-1:0] run_q, auto_q, wake_q, sleep_q, sleep_d, en_q;
    logic [prts_pkg::NUM_BASE-1:0] base_stat_q, base_idle_w;
    logic wr_pll, wr_run, wr_auto, wr_wake, wr_pmu, wake_go, aen_q;

    // apb decode: one wait-free access phase, data registered in setup
    assign setup = psel && !penable;
    assign acc_wr = psel && penable && pready_q && pwrite;
    assign wr_pll = acc_wr && reg_hit(paddr, prts_pkg::OFS_PLL_CTRL);
    assign wr_run = acc_wr && reg_hit(paddr, prts_pkg::OFS_BR_RUN);
    assign wr_auto = acc_wr && reg_hit(paddr, prts_pkg::OFS_BR_AUTO);
    assign wr_wake = acc_wr && reg_hit(paddr, prts_pkg::OFS_BR_WAKE);
    assign wr_pmu = acc_wr && reg_hit(paddr, prts_pkg::OFS_PMU_CTRL);
    assign rd_hit = reg_hit(paddr, prts_pkg::OFS_PLL_CTRL)
                  | reg_hit(paddr, prts_pkg::OFS_PLL_STAT)
                  | reg_hit(paddr, prts_pkg::OFS_RST_STAT)
                  | reg_hit(paddr, prts_pkg::OFS_BR_RUN)
                  | reg_hit(paddr, prts_pkg::OFS_BR_AUTO)
                  | reg_hit(paddr, prts_pkg::OFS_BR_WAKE)
                  | reg_hit(paddr, prts_pkg::OFS_PMU_CTRL)
                  | reg_hit(paddr, prts_pkg::OFS_BASE_STAT);
    assign rd_mux =
        reg_hit(paddr, prts_pkg::OFS_PLL_CTRL) ? {19'h0, pll_q} :
        reg_hit(paddr, prts_pkg::OFS_PLL_STAT) ? {31'h0, lock_q} :
        reg_hit(paddr, prts_pkg::OFS_RST_STAT) ? {28'h0, lvl_q} :
        reg_hit(paddr, prts_pkg::OFS_BR_RUN) ? {24'h0, run_q} :
        reg_hit(paddr, prts_pkg::OFS_BR_AUTO) ? {24'h0, auto_q} :
        reg_hit(paddr, prts_pkg::OFS_BR_WAKE) ? {24'h0, wake_q} :
        reg_hit(paddr, prts_pkg::OFS_PMU_CTRL) ? {31'h0, pm_q == prts_pkg::PM_DOWN} :
        reg_hit(paddr, prts_pkg::OFS_BASE_STAT) ? {23'h0, base_stat_q} : 32'h0;

    // apb answer flops; unmapped addresses answer with pslverr
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready_q <= 1'b0;
            pslverr_q <= 1'b0;
            prdata_q <= 32'h0;
        end else begin
            pready_q <= setup;
            pslverr_q <= setup && !rd_hit;
            prdata_q <= (setup && !pwrite) ? rd_mux : 32'h0;
        end
    end

    // pll control register; reserved bits stay zero so readback shows only real fields
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pll_q <= prts_pkg::PLL_CTRL_RST;
            aen_q <= 1'b0;
        end else begin
            aen_q <= !pll_q.pd;
            if (wr_pll) begin
                pll_q <= '{msel: pwdata[prts_pkg::PLL_MSEL_LSB +: 5],
                           rsvd: 3'h0,
                           psel: pwdata[prts_pkg::PLL_PSEL_LSB +: 2],
                           phase_outputs_enable: pwdata[prts_pkg::PLL_P23_BIT],
                           bypass: pwdata[prts_pkg::PLL_BYP_BIT],
                           pd: pwdata[prts_pkg::PLL_PD_BIT]};
            end
        end
    end

    // two-flop synchronisers; the third oscillator flop only feeds edge detection
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            osc_sync_q <= '0;
            lock_sync_q <= 2'h0;
            wake_sync_q <= 2'h0;
            ext_sync_q <= 2'h0;
            por_sync_q <= 2'h0;
        end else begin
            for (int k = 0; k < 3; k++) begin
                osc_sync_q[k] <= {osc_sync_q[k][1:0], controlled_oscillator[k]};
            end
            lock_sync_q <= {lock_sync_q[0], analog_lock};
            wake_sync_q <= {wake_sync_q[0], wake_event};
            ext_sync_q <= {ext_sync_q[0], external_reset_n};
            por_sync_q <= {por_sync_q[0], por_n};
        end
    end

    // half period of the post divider is P = 2^psel, full ratio 2P
    assign half = 4'(4'h1 << pll_q.psel);
    assign lock_rise = (lk_d == prts_pkg::LK_LOCKED) && (lk_q != prts_pkg::LK_LOCKED);

    // post dividers, one per phase; oscillator must stay below pclk/2 to be seen
    generate
        for (genvar k = 0; k < 3; k++) begin : g_phase
            assign osc_rise[k] = osc_sync_q[k][1] && !osc_sync_q[k][2];
            always_ff @(posedge pclk or negedge presetn) begin
                if (!presetn) begin
                    div_cnt_q[k] <= 4'h0;
                    div_out_q[k] <= 1'b0;
                end else if (pll_q.pd || (k != 0 && !pll_q.phase_outputs_enable)) begin
                    div_cnt_q[k] <= 4'h0;
                    div_out_q[k] <= 1'b0;
                end else if (k != 0 && lock_rise) begin
                    div_cnt_q[k] <= div_cnt_q[0];
                    div_out_q[k] <= div_out_q[0];
                end else if (pll_q.bypass) begin
                    div_out_q[k] <= osc_sync_q[k][1];
                end else if (osc_rise[k]) begin
                    div_cnt_q[k] <= (div_cnt_q[k] == half - 4'h1) ? 4'h0 : div_cnt_q[k] + 4'h1;
                    div_out_q[k] <= div_out_q[k] ^ (div_cnt_q[k] == half - 4'h1);
                end
            end
        end
    endgenerate

    // feedback divider counts main output rising edges; M of zero acts as one
    assign msel_eff = (pll_q.msel == 5'h0) ? 8'h1 : {3'h0, pll_q.msel};
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            main_prev_q <= 1'b0;
            fb_cnt_q <= 8'h0;
            fb_q <= 1'b0;
        end else if (pll_q.pd) begin
            main_prev_q <= 1'b0;
            fb_cnt_q <= 8'h0;
            fb_q <= 1'b0;
        end else begin
            main_prev_q <= div_out_q[0];
            if (div_out_q[0] && !main_prev_q) begin
                fb_cnt_q <= (fb_cnt_q >= msel_eff - 8'h1) ? 8'h0 : fb_cnt_q + 8'h1;
            end
            fb_q <= (fb_cnt_q < {1'b0, msel_eff[7:1]}) || (msel_eff == 8'h1 && div_out_q[0]);
        end
    end

    // lock detector: analog lock must hold for the settle count before flagging
    always_comb begin
        lk_d = lk_q;
        unique case (lk_q)
            prts_pkg::LK_OFF: if (!pll_q.pd && lock_sync_q[1]) lk_d = prts_pkg::LK_SETTLE;
            prts_pkg::LK_SETTLE: begin
                if (pll_q.pd || !lock_sync_q[1]) lk_d = prts_pkg::LK_OFF;
                else if (lk_cnt_q == prts_pkg::LOCK_SETTLE_CNT - 8'h1) lk_d = prts_pkg::LK_LOCKED;
            end
            prts_pkg::LK_LOCKED: if (pll_q.pd || !lock_sync_q[1]) lk_d = prts_pkg::LK_OFF;
            default: lk_d = prts_pkg::LK_OFF;
        endcase
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            lk_q <= prts_pkg::LK_OFF;
            lk_cnt_q <= 8'h0;
            lock_q <= 1'b0;
        end else begin
            lk_q <= lk_d;
            lk_cnt_q <= (lk_q == prts_pkg::LK_SETTLE) ? lk_cnt_q + 8'h1 : 8'h0;
            lock_q <= (lk_d == prts_pkg::LK_LOCKED) && !pll_q.pd;
        end
    end

    // reset cascade sources; por and pin are synchronised, watchdog is local
    assign lvl_src[0] = !por_sync_q[1] || !ext_sync_q[1];
    assign lvl_src[1] = lvl_q[0] || watchdog_rst;
    assign lvl_src[2] = lvl_q[1];
    assign lvl_src[3] = lvl_q[2];

    // each level asserts at once and releases after the stretch count
    generate
        for (genvar l = 0; l < prts_pkg::NUM_LVL; l++) begin : g_lvl
            always_ff @(posedge pclk or negedge presetn) begin
                if (!presetn) begin
                    lvl_q[l] <= 1'b1;
                    lvl_cnt_q[l] <= prts_pkg::RST_STRETCH_CNT;
                end else if (lvl_src[l]) begin
                    lvl_q[l] <= 1'b1;
                    lvl_cnt_q[l] <= prts_pkg::RST_STRETCH_CNT;
                end else if (lvl_cnt_q[l] != 8'h0) begin
                    lvl_cnt_q[l] <= lvl_cnt_q[l] - 8'h1;
                end else begin
                    lvl_q[l] <= 1'b0;
                end
            end
        end
    endgenerate

    // domain resets fan out from cold and warm levels, one flop each
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cold_dom_q <= '1;
            warm_dom_q <= '1;
        end else begin
            cold_dom_q <= {prts_pkg::NUM_COLD{lvl_q[2]}};
            warm_dom_q <= {prts_pkg::NUM_WARM{lvl_q[3]}};
        end
    end

    // power state: wake events only count while powered down
    assign wake_go = (pm_q == prts_pkg::PM_DOWN) && wake_sync_q[1];
    always_comb begin
        pm_d = pm_q;
        sleep_d = sleep_q;
        unique case (pm_q)
            prts_pkg::PM_RUN: begin
                if (wr_pmu && pwdata[prts_pkg::PMU_DOWN_BIT]) begin
                    pm_d = prts_pkg::PM_DOWN;
                    sleep_d = run_q & auto_q;
                end
                if (wr_run) sleep_d = '0;
            end
            prts_pkg::PM_DOWN: begin
                if (wake_go) begin
                    pm_d = prts_pkg::PM_RUN;
                    sleep_d = sleep_q & ~wake_q;
                end
            end
            default: pm_d = prts_pkg::PM_RUN;
        endcase
    end

    // branch config; tied bits are forced so writes cannot move them
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            run_q <= prts_pkg::BR_RUN_RST;
            auto_q <= 8'h0;
            wake_q <= 8'h0;
            pm_q <= prts_pkg::PM_RUN;
            sleep_q <= 8'h0;
        end else begin
            if (wr_run) run_q <= (pwdata[7:0] & ~prts_pkg::RUN_FIX_MASK)
                                 | prts_pkg::RUN_FIX_VAL;
            if (wr_auto) auto_q <= pwdata[7:0] & ~prts_pkg::AUTO_FIX_MASK;
            if (wr_wake) wake_q <= pwdata[7:0] & ~prts_pkg::WAKE_FIX_MASK;
            pm_q <= pm_d;
            sleep_q <= sleep_d;
        end
    end

    // fixed branch-to-base map drives the idle status of each base
    generate
        for (genvar b = 0; b < prts_pkg::NUM_BASE; b++) begin : g_base
            assign base_idle_w[b] = base_idle(en_q, 4'(b));
        end
    endgenerate

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            en_q <= 8'h0;
            base_stat_q <= '0;
        end else begin
            en_q <= run_q & ~sleep_q;
            base_stat_q <= base_idle_w;
        end
    end

    // outputs straight from flops
    assign prdata = prdata_q;
    assign pready = pready_q;
    assign pslverr = pslverr_q;
    assign pll_phase_out = div_out_q;
    assign pll_main_output = div_out_q[0];
    assign pll_fb_clk = fb_q;
    assign pll_analog_en = aen_q;
    assign pll_lock = lock_q;
    assign reset_unit_reset = lvl_q[0];
    assign subsystem_ctrl_reset = lvl_q[1];
    assign cold_level_reset = lvl_q[2];
    assign warm_level_reset = lvl_q[3];
    assign cold_domain_rst = cold_dom_q;
    assign warm_domain_rst = warm_dom_q;
    assign branch_clk_en = en_q;

    // checks
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    sequence s_cascade;
        lvl_q[1] ##1 lvl_q[2] ##1 lvl_q[3];
    endsequence

    a_pd_lock_low: assert property (pll_q.pd |=> !lock_q)
        else $error("lock high in powerdown");
    a_lock_settled: assert property ($rose(lock_q) |-> $past(lk_cnt_q) ==
        prts_pkg::LOCK_SETTLE_CNT - 8'h1 && $past(lock_sync_q[1]))
        else $error("lock without settle");
    a_phase_sync: assert property (lock_rise && pll_q.phase_outputs_enable |=>
        div_cnt_q[1] == $past(div_cnt_q[0]) && div_out_q[1] == $past(div_out_q[0]))
        else $error("phase divider not resynchronised at lock");
    a_pd_div_reset: assert property (pll_q.pd |=> div_cnt_q[0] == 4'h0 && !fb_q)
        else $error("divider live in powerdown");
    a_div_toggle: assert property ($changed(div_out_q[0]) && !$past(pll_q.bypass)
        && !$past(pll_q.pd) && !$past(lock_rise) |-> $past(osc_rise[0])
        && $past(div_cnt_q[0]) == $past(half) - 4'h1)
        else $error("post divider toggled off count");
    a_wdt_cascade: assert property (watchdog_rst |=> s_cascade)
        else $error("watchdog cascade broken");
    a_ext_reset: assert property (!ext_sync_q[1] |=> lvl_q[0] ##2 cold_level_reset)
        else $error("pin reset not applied");
    a_rst_stretch: assert property (lvl_src[0] |=> lvl_q[0] [*8])
        else $error("reset released early");
    a_warm_domain: assert property (lvl_q[3] |=> &warm_dom_q)
        else $error("warm domain reset missing");
    a_cold_domain: assert property (lvl_q[2] |=> &cold_dom_q)
        else $error("cold domain reset missing");
    a_tied_run: assert property ((run_q & prts_pkg::RUN_FIX_MASK)
        == prts_pkg::RUN_FIX_VAL && (wake_q & prts_pkg::WAKE_FIX_MASK) == 8'h0)
        else $error("tied bit moved");
    a_pd_sleep: assert property (wr_pmu && pwdata[0] && pm_q == prts_pkg::PM_RUN
        |=> ##1 (branch_clk_en & auto_q) == 8'h0)
        else $error("auto branch still running");

endmodule // prts_top

/* File: testbench/prts_partner.sv */
`timescale 1ns/10ps
// model of the analog pll core: three oscillator phases and a slow lock flag
module prts_partner #(
    parameter int LOCK_DLY = 20
) (
    // clock
    input wire logic pclk,
    // analog core side
    input wire logic analog_en,
    output logic [2:0] osc,
    output logic lock
);
    logic [7:0] cnt_q = 8'h00;
    logic [7:0] lk_q = 8'h00;
    logic [7:0] c1;
    logic [7:0] c2;
    // oscillator and lock stand still while the core is off, so lock can never lie
    always_ff @(posedge pclk) begin
        cnt_q <= analog_en ? cnt_q + 8'h01 : 8'h00;
        lk_q <= !analog_en ? 8'h00 : (lk_q == 8'(LOCK_DLY)) ? lk_q : lk_q + 8'h01;
    end
    // phases about a third of an 8-cycle period apart
    assign c1 = cnt_q + 8'h03;
    assign c2 = cnt_q + 8'h05;
    assign osc = {c2[2], c1[2], cnt_q[2]};
    assign lock = (lk_q == 8'(LOCK_DLY));
endmodule // prts_partner

/* File: testbench/tb_pll_reset_tree_clock_gating.sv */
`timescale 1ns/10ps
module tb_pll_reset_tree_clock_gating;
    logic pclk = 1'b0;
    logic presetn, psel, penable, pwrite, pready, pslverr;
    logic [7:0] paddr;
    logic [31:0] pwdata, prdata;
    logic [2:0] osc, ph;
    logic alock, main_out, fb_clk, aen, lock, por_n, ext_n, wdog, wake;
    logic [3:0] lvl;
    logic [prts_pkg::NUM_COLD-1:0] cdom;
    logic [prts_pkg::NUM_WARM-1:0] wdom;
    logic [prts_pkg::NUM_BR-1:0] br_en;
    logic [32:0] exp_q[$];
    logic [32:0] msk_q[$];
    logic [31:0] lfsr = 32'h1098e7d0;
    int bad_count = 0;
    int comparisons = 0;
    int per;
    int i;

    always #4 pclk = ~pclk;

    prts_top prts_top_i (.pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel),
        .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .controlled_oscillator(osc),
        .analog_lock(alock), .pll_phase_out(ph), .pll_main_output(main_out),
        .pll_fb_clk(fb_clk), .pll_analog_en(aen), .pll_lock(lock), .por_n(por_n),
        .external_reset_n(ext_n), .watchdog_rst(wdog), .reset_unit_reset(lvl[3]),
        .subsystem_ctrl_reset(lvl[2]), .cold_level_reset(lvl[1]),
        .warm_level_reset(lvl[0]), .cold_domain_rst(cdom), .warm_domain_rst(wdom),
        .wake_event(wake), .branch_clk_en(br_en));
    prts_partner prts_partner_i (.pclk(pclk), .analog_en(aen), .osc(osc), .lock(alock));

    task automatic chk(input logic [32:0] seen, input logic [32:0] exp);
        comparisons++;
        if (seen !== exp) begin
            bad_count++;
            $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    task automatic results();
        $display("comparisons %0d mismatches %0d", comparisons, bad_count);
        if (bad_count == 0 && comparisons > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask

    task automatic fail_out();
        bad_count++;
        results();
    endtask

    // next value of the stimulus sequence
    function automatic logic [31:0] lfsr_next(input logic [31:0] v);
        return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
    endfunction

    task automatic cyc(input int n);
        repeat (n) @(posedge pclk);
    endtask

    // one apb transfer; writes only check the error flag
    task automatic apb(input logic [7:0] a, input logic w, input logic [31:0] d,
            input logic [32:0] e);
        int k;
        exp_q.push_back(e);
        msk_q.push_back(w ? 33'h100000000 : 33'h1ffffffff);
        // one idle edge so psel is never written twice in one step
        @(posedge pclk);
        psel <= 1'b1;
        paddr <= a;
        pwrite <= w;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        k = 0;
        do begin
            @(posedge pclk);
            k++;
            if (k > 16) fail_out();
        end while (pready !== 1'b1);
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    // answer watcher: each completed transfer against the oldest note
    always @(posedge pclk) begin
        if (psel && penable && pready === 1'b1 && exp_q.size() > 0) begin
            chk({pslverr, prdata} & msk_q[0], exp_q[0] & msk_q[0]);
            void'(exp_q.pop_front());
            void'(msk_q.pop_front());
        end
    end

    // cycles between two rises of main (0), feedback (1) or phase one (2)
    task automatic meas(input int s, output int p);
        int k, r;
        logic pv, cv;
        r = 0;
        p = 0;
        pv = 1'b1;
        for (k = 0; k < 3000 && r < 2; k++) begin
            @(posedge pclk);
            cv = (s == 0) ? main_out : (s == 1) ? fb_clk : ph[1];
            if (r == 1) p++;
            if (cv === 1'b1 && pv === 1'b0) r++;
            pv = cv;
        end
        if (r < 2) fail_out();
    endtask

    // every reset level must clear after its stretch
    task automatic rel_wait();
        int k;
        for (k = 0; k < 500 && {lvl, cdom, wdom} !== '0; k++) @(posedge pclk);
        chk(33'({lvl, cdom, wdom}), 33'h0);
    endtask

    initial begin
        {presetn, psel, penable, pwrite, wdog, wake} = '0;
        {por_n, ext_n} = 2'b11;
        paddr = 8'h00;
        pwdata = 32'h0;
        cyc(2);
        presetn <= 1'b1;
        cyc(50);
        chk(33'(lvl), 33'hf);
        rel_wait();
        apb(prts_pkg::OFS_PLL_CTRL, 1'b0, 32'h0, 33'(prts_pkg::PLL_CTRL_RST));
        apb(prts_pkg::OFS_PLL_STAT, 1'b0, 32'h0, 33'h0);
        apb(prts_pkg::OFS_BR_RUN, 1'b0, 32'h0, 33'hff);
        apb(8'h20, 1'b1, 32'h5, 33'h100000000);
        apb(prts_pkg::OFS_BR_RUN, 1'b1, 32'h0, 33'h0);
        apb(prts_pkg::OFS_BR_RUN, 1'b0, 32'h0, 33'h0b);
        apb(prts_pkg::OFS_BASE_STAT, 1'b0, 32'h0, 33'h1f8);
        chk(33'(br_en), 33'h0b);
        lfsr = lfsr_next(lfsr);
        apb(prts_pkg::OFS_BR_AUTO, 1'b1, lfsr, 33'h0);
        apb(prts_pkg::OFS_BR_AUTO, 1'b0, 32'h0, {25'h0, lfsr[7:1], 1'b0});
        // power-down stops auto clocks except branch 0, whose auto bit is tied off; wake restarts wake-enabled ones
        // base clocks never stop in this bench, so re-enabling is always allowed
        apb(prts_pkg::OFS_BR_RUN, 1'b1, 32'hff, 33'h0);
        apb(prts_pkg::OFS_BR_AUTO, 1'b1, 32'hf2, 33'h0);
        apb(prts_pkg::OFS_BR_WAKE, 1'b1, 32'h30, 33'h0);
        apb(prts_pkg::OFS_PMU_CTRL, 1'b1, 32'h1, 33'h0);
        cyc(3);
        chk(33'(br_en), 33'h0d);
        wake <= 1'b1;
        cyc(2);
        wake <= 1'b0;
        cyc(6);
        chk(33'(br_en), 33'h3d);
        apb(prts_pkg::OFS_PMU_CTRL, 1'b0, 32'h0, 33'h0);
        // power up with feedback ratio 4; lock only after the settle time
        apb(prts_pkg::OFS_PLL_CTRL, 1'b1, 32'h400, 33'h0);
        cyc(100);
        chk(33'(lock), 33'h0);
        for (i = 0; i < 600 && lock !== 1'b1; i++) @(posedge pclk);
        chk(33'(lock), 33'h1);
        // ascending divide settings first, bypass last
        for (i = 0; i < 5; i++) begin
            apb(prts_pkg::OFS_PLL_CTRL, 1'b1, (i < 4) ? 32'h400 | (i << 3) : 32'h402, 33'h0);
            cyc(300);
            meas(0, per);
            chk(33'(per), (i < 4) ? 33'(16 << i) : 33'h8);
            meas(1, per);
            chk(33'(per), (i < 4) ? 33'(64 << i) : 33'h20);
        end
        chk(33'(ph[2:1]), 33'h0);
        apb(prts_pkg::OFS_PLL_CTRL, 1'b1, 32'h404, 33'h0);
        cyc(300);
        meas(2, per);
        chk(33'(per), 33'h10);
        apb(prts_pkg::OFS_PLL_CTRL, 1'b1, 32'h405, 33'h0);
        cyc(3);
        chk(33'({lock, aen, ph, main_out, fb_clk}), 33'h0);
        // relock with the phase outputs on, so the phase dividers resync at lock
        apb(prts_pkg::OFS_PLL_CTRL, 1'b1, 32'h404, 33'h0);
        for (i = 0; i < 600 && lock !== 1'b1; i++) @(posedge pclk);
        chk(33'(lock), 33'h1);
        // watchdog walks down the cascade one level a cycle
        wdog <= 1'b1;
        cyc(2);
        wdog <= 1'b0;
        chk(33'(lvl), 33'h4);
        cyc(2);
        chk(33'({lvl, cdom}), 33'hff);
        cyc(1);
        chk(33'(wdom), 33'h7ff);
        rel_wait();
        ext_n <= 1'b0;
        cyc(7);
        chk(33'({lvl[3], cdom}), 33'h3f);
        ext_n <= 1'b1;
        rel_wait();
        results();
    end
endmodule // tb_pll_reset_tree_clock_gating
